/* dtc_pin_model.sv */
// Pin-side model: two count pins and two active-low interrupt pins
`timescale 1ns/1ps
`default_nettype none
module dtc_pin_model (
  input  wire logic       hclk,
  output logic      [3:0] pins
);
  // Idle high as with a pull-up; bit order follows the pin sync vector
  initial pins = 4'hf;

  // Falling pulses, three cycles low and four high between pulses, above the sync minimum
  task automatic pulse(input int p, input int n);
    repeat (n) begin
      @(posedge hclk) pins[p] <= 1'b0;
      repeat (3) @(posedge hclk);
      pins[p] <= 1'b1;
      repeat (3) @(posedge hclk);
    end
  endtask

  // Held level for gating and level triggering
  task automatic hold(input int p, input logic v);
    @(posedge hclk) pins[p] <= v;
  endtask
endmodule
`default_nettype wire

/* dtc_pin_sync.sv */
// Two-stage synchroniser and falling-edge detector for the block's pins
`timescale 1ns/1ps
`default_nettype none
module dtc_pin_sync #(
  parameter int N = 4
) (
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic [N-1:0] pin_in,
  output logic      [N-1:0] pin_lvl,
  output logic      [N-1:0] pin_fall
);

  typedef struct packed {
    logic [N-1:0] meta;
    logic [N-1:0] sync;
    logic [N-1:0] prev;
  } dtc_sync_t;

  dtc_sync_t state_r;
  dtc_sync_t state_nxt;

  // Meta stage feeds only the sync stage
  always_comb begin
    state_nxt      = state_r;
    state_nxt.meta = pin_in;
    state_nxt.sync = state_r.meta;
    state_nxt.prev = state_r.sync;
  end

  // Pins idle high, so reset to ones to avoid a false edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= '{meta: '1, sync: '1, prev: '1};
    end else begin
      state_r <= state_nxt;
    end
  end

  // Level and edge outputs per pin
  generate
    for (genvar i = 0; i < N; i++) begin : g_pin
      assign pin_lvl[i]  = state_r.sync[i];
      assign pin_fall[i] = state_r.prev[i] & ~state_r.sync[i];
    end
  endgenerate

endmodule
`default_nettype wire

/* dtc_pkg.sv */
// Package with register map, field layout and encodings of the timer block
package dtc_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_TIMER_CONTROL      = 8'h88;
  localparam logic [7:0] IDX_TIMER_MODE_CONTROL = 8'h89;
  localparam logic [7:0] IDX_TIMER0_COUNT_LOW   = 8'h8a;
  localparam logic [7:0] IDX_TIMER1_COUNT_LOW   = 8'h8b;
  localparam logic [7:0] IDX_TIMER0_COUNT_HIGH  = 8'h8c;
  localparam logic [7:0] IDX_TIMER1_COUNT_HIGH  = 8'h8d;

  // Reset value of every register
  localparam logic [7:0] RST_BYTE = 8'h00;

  // Timer control bit positions
  localparam int BIT_T1_OVF  = 7;
  localparam int BIT_T1_RUN  = 6;
  localparam int BIT_T0_OVF  = 5;
  localparam int BIT_T0_RUN  = 4;
  localparam int BIT_X1_FLAG = 3;
  localparam int BIT_X1_TYPE = 2;
  localparam int BIT_X0_FLAG = 1;
  localparam int BIT_X0_TYPE = 0;

  // Mode register: one nibble per timer
  localparam int FLD_T0   = 0;
  localparam int FLD_T1   = 4;
  localparam int OFS_MODE = 0;
  localparam int OFS_CT   = 2;
  localparam int OFS_GATE = 3;

  // Pin vector order inside the synchroniser
  localparam int PIN_T0   = 0;
  localparam int PIN_T1   = 1;
  localparam int PIN_INT0 = 2;
  localparam int PIN_INT1 = 3;
  localparam int NUM_PINS = 4;

  // Prescaler width of mode 0
  localparam int PRE_BITS = 5;

  // AHB-Lite encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD    = 3'h2;

  typedef enum logic [1:0] {
    MODE_PRESCALED = 2'h0,
    MODE_WIDE      = 2'h1,
    MODE_RELOAD    = 2'h2,
    MODE_SPLIT     = 2'h3
  } dtc_mode_t;

  typedef enum logic [3:0] {
    BUS_IDLE   = 4'h1,
    BUS_WRITE  = 4'h2,
    BUS_RDWAIT = 4'h4,
    BUS_RDDATA = 4'h8
  } dtc_bus_t;

endpackage

/* dtc_top.sv */
// Dual timer/counter with external interrupt flags behind AHB-Lite
`timescale 1ns/1ps
`default_nettype none
module dtc_top (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        t0_count_pin,
  input  wire logic        t1_count_pin,
  input  wire logic        external_irq0_pin_n,
  input  wire logic        external_irq1_pin_n,
  input  wire logic        timer0_vector_ack,
  input  wire logic        timer1_vector_ack,
  input  wire logic        ext_irq0_vector_ack,
  input  wire logic        ext_irq1_vector_ack,
  output logic             timer0_overflow_flag,
  output logic             timer1_overflow_flag,
  output logic             ext_irq0_flag,
  output logic             ext_irq1_flag
);

  typedef struct packed {
    logic [7:0]       timer_control;
    logic [7:0]       timer_mode_control;
    logic [7:0]       timer0_count_low;
    logic [7:0]       timer1_count_low;
    logic [7:0]       timer0_count_high;
    logic [7:0]       timer1_count_high;
    logic [7:0]       rdata;
    logic [7:0]       idx;
    logic             wr;
    dtc_pkg::dtc_bus_t bus;
  } dtc_state_t;

  dtc_state_t state_r;
  dtc_state_t state_nxt;

  logic [dtc_pkg::NUM_PINS-1:0] pin_raw;
  logic [dtc_pkg::NUM_PINS-1:0] pin_lvl;
  logic [dtc_pkg::NUM_PINS-1:0] pin_fall;

  // Combinational helpers, all set in the one combinational process
  logic       accept;
  logic       mapped;
  logic       wr_now;
  logic [1:0] mode0;
  logic [1:0] mode1;
  logic       inc0;
  logic       inc1;
  logic       inc0_high;
  logic       t0_ovf;
  logic       t1_set;
  logic [16:0] step0;
  logic [16:0] step1;
  logic [8:0]  high0_sum;
  logic [7:0]  ctl_base;

  assign pin_raw[dtc_pkg::PIN_T0]   = t0_count_pin;
  assign pin_raw[dtc_pkg::PIN_T1]   = t1_count_pin;
  assign pin_raw[dtc_pkg::PIN_INT0] = external_irq0_pin_n;
  assign pin_raw[dtc_pkg::PIN_INT1] = external_irq1_pin_n;

  // Pins come from outside the clock domain
  dtc_pin_sync #(
    .N (dtc_pkg::NUM_PINS)
  ) u_sync (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .pin_in   (pin_raw),
    .pin_lvl  (pin_lvl),
    .pin_fall (pin_fall)
  );

  // Count enable from run, gate and pin level
  function automatic logic count_en(input logic run, input logic gate,
                                    input logic lvl);
    count_en = run & (~gate | lvl);
  endfunction

  // One step of a timer in modes 0 to 2; mode 3 steps only the low byte
  function automatic logic [16:0] step(input logic [1:0] m,
                                       input logic [7:0] tl,
                                       input logic [7:0] th,
                                       input logic       inc);
    logic [13:0] c13;
    logic [16:0] c16;
    logic [8:0]  c8;
    c13  = {1'b0, th, tl[dtc_pkg::PRE_BITS-1:0]} + 14'h0001;
    c16  = {1'b0, th, tl} + 17'h0_0001;
    c8   = {1'b0, tl} + 9'h001;
    step = {1'b0, th, tl};
    if (inc) begin
      unique case (m)
        dtc_pkg::MODE_PRESCALED: begin
          // Upper three low-byte bits are left as software wrote them
          step = {c13[13], c13[12:dtc_pkg::PRE_BITS],
                  tl[7:dtc_pkg::PRE_BITS],
                  c13[dtc_pkg::PRE_BITS-1:0]};
        end
        dtc_pkg::MODE_WIDE: begin
          step = c16;
        end
        dtc_pkg::MODE_RELOAD: begin
          step = {c8[8], th, c8[8] ? th : c8[7:0]};
        end
        dtc_pkg::MODE_SPLIT: begin
          step = {c8[8], th, c8[7:0]};
        end
      endcase
    end
  endfunction

  // Register read multiplexer; unmapped words read zero
  function automatic logic [7:0] rd_mux(input dtc_state_t s);
    unique case (s.idx)
      dtc_pkg::IDX_TIMER_CONTROL:      rd_mux = s.timer_control;
      dtc_pkg::IDX_TIMER_MODE_CONTROL: rd_mux = s.timer_mode_control;
      dtc_pkg::IDX_TIMER0_COUNT_LOW:   rd_mux = s.timer0_count_low;
      dtc_pkg::IDX_TIMER1_COUNT_LOW:   rd_mux = s.timer1_count_low;
      dtc_pkg::IDX_TIMER0_COUNT_HIGH:  rd_mux = s.timer0_count_high;
      dtc_pkg::IDX_TIMER1_COUNT_HIGH:  rd_mux = s.timer1_count_high;
      default:                         rd_mux = dtc_pkg::RST_BYTE;
    endcase
  endfunction

  // Next-state logic: bus slave, timers, flags
  always_comb begin
    state_nxt = state_r;

    // Address phase taken when selected and bus ready
    accept = hsel & hready & (htrans == dtc_pkg::HTRANS_NONSEQ);
    mapped = (haddr[31:10] == 22'h00_0000) && (haddr[1:0] == 2'h0)
             && (haddr[9:2] >= dtc_pkg::IDX_TIMER_CONTROL)
             && (haddr[9:2] <= dtc_pkg::IDX_TIMER1_COUNT_HIGH)
             && (hsize == dtc_pkg::HSIZE_WORD);
    // Writes commit at the end of their zero-wait data phase
    wr_now = (state_r.bus == dtc_pkg::BUS_WRITE) & state_r.wr;

    unique case (state_r.bus)
      dtc_pkg::BUS_RDWAIT: begin
        // One wait state lets a just-committed write be read back
        state_nxt.rdata = rd_mux(state_r);
        state_nxt.bus   = dtc_pkg::BUS_RDDATA;
      end
      dtc_pkg::BUS_IDLE, dtc_pkg::BUS_WRITE,
      dtc_pkg::BUS_RDDATA: begin
        if (accept) begin
          state_nxt.idx = mapped ? haddr[9:2] : dtc_pkg::RST_BYTE;
          state_nxt.wr  = hwrite & mapped;
          state_nxt.bus = hwrite ? dtc_pkg::BUS_WRITE
                                 : dtc_pkg::BUS_RDWAIT;
        end else begin
          state_nxt.wr  = 1'b0;
          state_nxt.bus = dtc_pkg::BUS_IDLE;
        end
      end
    endcase

    // Mode fields of each timer
    mode0 = state_r.timer_mode_control[dtc_pkg::FLD_T0 +
                                       dtc_pkg::OFS_MODE +: 2];
    mode1 = state_r.timer_mode_control[dtc_pkg::FLD_T1 +
                                       dtc_pkg::OFS_MODE +: 2];

    // Timer 0 increment: internal clock or pin falling edge
    inc0 = count_en(state_r.timer_control[dtc_pkg::BIT_T0_RUN],
             state_r.timer_mode_control[dtc_pkg::FLD_T0 +
                                        dtc_pkg::OFS_GATE],
             pin_lvl[dtc_pkg::PIN_INT0])
           & (state_r.timer_mode_control[dtc_pkg::FLD_T0 +
                                         dtc_pkg::OFS_CT]
              ? pin_fall[dtc_pkg::PIN_T0] : 1'b1);

    // Timer 1 increment; held still in mode 3
    inc1 = count_en(state_r.timer_control[dtc_pkg::BIT_T1_RUN],
             state_r.timer_mode_control[dtc_pkg::FLD_T1 +
                                        dtc_pkg::OFS_GATE],
             pin_lvl[dtc_pkg::PIN_INT1])
           & (state_r.timer_mode_control[dtc_pkg::FLD_T1 +
                                         dtc_pkg::OFS_CT]
              ? pin_fall[dtc_pkg::PIN_T1] : 1'b1)
           & (mode1 != dtc_pkg::MODE_SPLIT);

    step0 = step(mode0, state_r.timer0_count_low,
                 state_r.timer0_count_high, inc0);
    step1 = step(mode1, state_r.timer1_count_low,
                 state_r.timer1_count_high, inc1);

    // Split mode: timer 0 high byte is an internal timer on timer 1 run
    inc0_high = (mode0 == dtc_pkg::MODE_SPLIT)
                & state_r.timer_control[dtc_pkg::BIT_T1_RUN];
    high0_sum = {1'b0, state_r.timer0_count_high} + 9'h001;

    state_nxt.timer0_count_low  = step0[7:0];
    state_nxt.timer0_count_high = inc0_high ? high0_sum[7:0]
                                            : step0[15:8];
    state_nxt.timer1_count_low  = step1[7:0];
    state_nxt.timer1_count_high = step1[15:8];

    // Timer 1 flag belongs to timer 0 high byte while timer 0 splits
    t0_ovf = step0[16];
    t1_set = (inc0_high & high0_sum[8])
             | (step1[16] & (mode0 != dtc_pkg::MODE_SPLIT));

    // Software writes win over counting on count and mode registers
    if (wr_now) begin
      unique case (state_r.idx)
        dtc_pkg::IDX_TIMER_MODE_CONTROL:
          state_nxt.timer_mode_control = hwdata[7:0];
        dtc_pkg::IDX_TIMER0_COUNT_LOW:
          state_nxt.timer0_count_low = hwdata[7:0];
        dtc_pkg::IDX_TIMER1_COUNT_LOW:
          state_nxt.timer1_count_low = hwdata[7:0];
        dtc_pkg::IDX_TIMER0_COUNT_HIGH:
          state_nxt.timer0_count_high = hwdata[7:0];
        dtc_pkg::IDX_TIMER1_COUNT_HIGH:
          state_nxt.timer1_count_high = hwdata[7:0];
        default: begin
        end
      endcase
    end

    // Control: software value, then vector clears, then hardware sets
    ctl_base = (wr_now && state_r.idx == dtc_pkg::IDX_TIMER_CONTROL)
               ? hwdata[7:0] : state_r.timer_control;
    if (timer0_vector_ack) begin
      ctl_base[dtc_pkg::BIT_T0_OVF] = 1'b0;
    end
    if (timer1_vector_ack) begin
      ctl_base[dtc_pkg::BIT_T1_OVF] = 1'b0;
    end
    // Vector clear of external flags only in edge mode
    if (ext_irq0_vector_ack && ctl_base[dtc_pkg::BIT_X0_TYPE]) begin
      ctl_base[dtc_pkg::BIT_X0_FLAG] = 1'b0;
    end
    if (ext_irq1_vector_ack && ctl_base[dtc_pkg::BIT_X1_TYPE]) begin
      ctl_base[dtc_pkg::BIT_X1_FLAG] = 1'b0;
    end
    // Set wins so no overflow is lost to a clear
    if (t0_ovf) begin
      ctl_base[dtc_pkg::BIT_T0_OVF] = 1'b1;
    end
    if (t1_set) begin
      ctl_base[dtc_pkg::BIT_T1_OVF] = 1'b1;
    end
    // Edge mode latches a fall; level mode follows the low pin
    if (ctl_base[dtc_pkg::BIT_X0_TYPE]) begin
      ctl_base[dtc_pkg::BIT_X0_FLAG] = ctl_base[dtc_pkg::BIT_X0_FLAG]
                                       | pin_fall[dtc_pkg::PIN_INT0];
    end else begin
      ctl_base[dtc_pkg::BIT_X0_FLAG] =
        ~pin_lvl[dtc_pkg::PIN_INT0];
    end
    if (ctl_base[dtc_pkg::BIT_X1_TYPE]) begin
      ctl_base[dtc_pkg::BIT_X1_FLAG] = ctl_base[dtc_pkg::BIT_X1_FLAG]
                                       | pin_fall[dtc_pkg::PIN_INT1];
    end else begin
      ctl_base[dtc_pkg::BIT_X1_FLAG] =
        ~pin_lvl[dtc_pkg::PIN_INT1];
    end
    state_nxt.timer_control = ctl_base;
  end

  // All registers clear on reset except bus, which loads BUS_IDLE
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= '{timer_control:      dtc_pkg::RST_BYTE,
                   timer_mode_control: dtc_pkg::RST_BYTE,
                   timer0_count_low:   dtc_pkg::RST_BYTE,
                   timer1_count_low:   dtc_pkg::RST_BYTE,
                   timer0_count_high:  dtc_pkg::RST_BYTE,
                   timer1_count_high:  dtc_pkg::RST_BYTE,
                   rdata:              dtc_pkg::RST_BYTE,
                   idx:                dtc_pkg::RST_BYTE,
                   wr:                 1'b0,
                   bus:                dtc_pkg::BUS_IDLE};
    end else begin
      state_r <= state_nxt;
    end
  end

  // Bus and flag outputs
  assign hreadyout = (state_r.bus != dtc_pkg::BUS_RDWAIT);
  assign hresp     = 1'b0;
  assign hrdata    = {24'h00_0000, state_r.rdata};
  assign timer0_overflow_flag = state_r.timer_control[dtc_pkg::BIT_T0_OVF];
  assign timer1_overflow_flag = state_r.timer_control[dtc_pkg::BIT_T1_OVF];
  assign ext_irq0_flag        = state_r.timer_control[dtc_pkg::BIT_X0_FLAG];
  assign ext_irq1_flag        = state_r.timer_control[dtc_pkg::BIT_X1_FLAG];

  // Checks on the timer, flag and bus behaviour
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  property p_tf0_set;
    t0_ovf |=> timer0_overflow_flag;
  endproperty
  a_tf0_set: assert property (p_tf0_set)
    else $error("timer 0 overflow did not set its flag");

  property p_tf1_clear;
    timer1_vector_ack && !t1_set && !wr_now |=> !timer1_overflow_flag;
  endproperty
  a_tf1_clear: assert property (p_tf1_clear)
    else $error("timer 1 flag not cleared at vectoring");

  property p_ie0_level;
    !state_r.timer_control[dtc_pkg::BIT_X0_TYPE] && !wr_now
      |=> ext_irq0_flag == !$past(pin_lvl[dtc_pkg::PIN_INT0]);
  endproperty
  a_ie0_level: assert property (p_ie0_level)
    else $error("level mode flag does not follow pin");

  property p_ie1_edge;
    state_r.timer_control[dtc_pkg::BIT_X1_TYPE] && !wr_now
      && pin_fall[dtc_pkg::PIN_INT1] |=> ext_irq1_flag;
  endproperty
  a_ie1_edge: assert property (p_ie1_edge)
    else $error("edge mode flag not set on falling edge");

  property p_stop_holds;
    !state_r.timer_control[dtc_pkg::BIT_T0_RUN] && !wr_now
      |=> $stable(state_r.timer0_count_low);
  endproperty
  a_stop_holds: assert property (p_stop_holds)
    else $error("timer 0 low byte moved while stopped");

  property p_gate_holds;
    state_r.timer_mode_control[dtc_pkg::FLD_T0 + dtc_pkg::OFS_GATE]
      && !pin_lvl[dtc_pkg::PIN_INT0] && !wr_now
      |=> $stable(state_r.timer0_count_low);
  endproperty
  a_gate_holds: assert property (p_gate_holds)
    else $error("gated timer counted while pin low");

  property p_t1_split_stop;
    mode1 == dtc_pkg::MODE_SPLIT && !wr_now
      |=> $stable({state_r.timer1_count_high, state_r.timer1_count_low});
  endproperty
  a_t1_split_stop: assert property (p_t1_split_stop)
    else $error("timer 1 counted in mode 3");

  property p_reload;
    mode0 == dtc_pkg::MODE_RELOAD && inc0 && !wr_now
      && state_r.timer0_count_low == 8'hff
      |=> state_r.timer0_count_low == $past(state_r.timer0_count_high)
          && timer0_overflow_flag;
  endproperty
  a_reload: assert property (p_reload)
    else $error("mode 2 reload or flag wrong");

  property p_wide_inc;
    mode0 == dtc_pkg::MODE_WIDE && inc0 && !wr_now
      |=> {state_r.timer0_count_high, state_r.timer0_count_low}
          == 16'($past({state_r.timer0_count_high,
                        state_r.timer0_count_low}) + 16'h0001);
  endproperty
  a_wide_inc: assert property (p_wide_inc)
    else $error("mode 1 did not step the 16-bit count");

  property p_read_wait;
    !hreadyout |=> hreadyout;
  endproperty
  a_read_wait: assert property (p_read_wait)
    else $error("read wait state longer than one cycle");

  c_tf0_ovf: cover property (t0_ovf);
  c_reload: cover property (mode0 == dtc_pkg::MODE_RELOAD && t0_ovf);
  c_ie1_edge: cover property (pin_fall[dtc_pkg::PIN_INT1]
                              && state_r.timer_control[dtc_pkg::BIT_X1_TYPE]);
  c_read_done: cover property (state_r.bus == dtc_pkg::BUS_RDDATA);

endmodule
`default_nettype wire

/* tb_dual_timer_counter_ext_irq.sv */
// Self-checking bench for the dual timer/counter block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, s) begin samples_checked++; if ((s) !== (e)) begin \
  error_cnt++; $display("BAD %s exp %h seen %h", nm, e, s); end end
module tb_dual_timer_counter_ext_irq;
  logic        hclk, hresetn, hsel, hwrite, hready, hresp, hreadyout;
  logic [31:0] haddr, hwdata, hrdata, seed;
  logic [1:0]  htrans;
  logic [3:0]  pins, ack, flg;
  logic [7:0]  rd, v, ls, hs;
  logic [7:0]  mdl [6];
  logic [7:0]  ix [6] = '{dtc_pkg::IDX_TIMER_CONTROL,
    dtc_pkg::IDX_TIMER_MODE_CONTROL, dtc_pkg::IDX_TIMER0_COUNT_LOW,
    dtc_pkg::IDX_TIMER1_COUNT_LOW, dtc_pkg::IDX_TIMER0_COUNT_HIGH,
    dtc_pkg::IDX_TIMER1_COUNT_HIGH};
  int          error_cnt = 0;
  int          samples_checked = 0;

  // Single slave, so its ready is the bus ready
  assign hready = hreadyout;

  dtc_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(dtc_pkg::HSIZE_WORD), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .t0_count_pin(pins[0]), .t1_count_pin(pins[1]),
    .external_irq0_pin_n(pins[2]), .external_irq1_pin_n(pins[3]),
    .timer0_vector_ack(ack[0]), .timer1_vector_ack(ack[1]),
    .ext_irq0_vector_ack(ack[2]), .ext_irq1_vector_ack(ack[3]),
    .timer0_overflow_flag(flg[0]), .timer1_overflow_flag(flg[1]),
    .ext_irq0_flag(flg[2]), .ext_irq1_flag(flg[3]));

  dtc_pin_model pin_u (.hclk(hclk), .pins(pins));

  // Clock at 100 ns period
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // One single AHB transfer; waits on ready, so no latency is assumed
  task automatic bus(input logic w, input logic [7:0] idx,
                     input logic [7:0] wd);
    logic r;
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {22'h0, idx, 2'b00};
    htrans <= dtc_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    // Ready read mid-cycle: the value the coming rising edge samples
    do begin
      @(negedge hclk);
      r = hready;
      @(posedge hclk);
    end while (r !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    do begin
      @(negedge hclk);
      r  = hready;
      rd = hrdata[7:0];
      @(posedge hclk);
    end while (r !== 1'b1);
    `CHK("hresp", 1'b0, hresp)
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d);
  endtask

  // Vector pulse of one cycle, then one edge for the clear to land
  task automatic kick(input int a);
    @(posedge hclk) ack[a] <= 1'b1;
    @(posedge hclk) ack[a] <= 1'b0;
    @(posedge hclk);
  endtask

  // Run one timer to overflow, vector it, stop it and read it back
  task automatic ovf(input int t, input logic [7:0] md, hi, lo);
    wr(ix[4+t], hi);
    wr(ix[2+t], lo);
    wr(ix[1], md);
    wr(ix[0], t ? 8'h40 : 8'h10);
    while (flg[t] !== 1'b1) @(posedge hclk);
    kick(t);
    `CHK("ovf ack", 1'b0, flg[t])
    wr(ix[0], 8'h00);
    bus(1'b0, ix[2+t], 8'h00);
    ls = rd;
    bus(1'b0, ix[4+t], 8'h00);
    hs = rd;
  endtask

  task automatic fin(input string s);
    $display("test %s done", s);
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Hang guard, far beyond the few hundred cycles the tests need
  initial begin
    repeat (30000) @(posedge hclk);
    error_cnt++;
    give_verdict();
  end

  initial begin
    {hsel, hwrite, haddr, hwdata, htrans, ack} = '0;
    hresetn = 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    // Reset values, then a hole in the map that must stay empty
    for (int i = 0; i < 6; i++) begin
      bus(1'b0, ix[i], 8'h00);
      `CHK("reset", 8'h00, rd)
    end
    wr(8'h8e, 8'h5a);
    bus(1'b0, 8'h8e, 8'h00);
    `CHK("hole", 8'h00, rd)
    fin("reset");
    // Random contents; run bits kept clear so nothing counts
    seed = 32'h19528a15;
    for (int i = 5; i >= 0; i--) begin
      seed = lfsr(seed);
      mdl[i] = i ? seed[7:0] : (seed[7:0] & 8'haf) | 8'h05;
      wr(ix[i], mdl[i]);
    end
    v = mdl[0];
    for (int i = 0; i < 6; i++) begin
      bus(1'b0, ix[i], 8'h00);
      `CHK("reg", mdl[i], rd)
    end
    `CHK("flags", {v[7], v[5], v[3], v[1]}, {flg[1:0], flg[3:2]})
    wr(ix[0], 8'h00);
    fin("regs");
    // Overflow in modes 1, 0 and 2
    ovf(0, 8'h01, 8'hff, 8'hf0);
    `CHK("m1 hi", 8'h00, hs)
    `CHK("m1 lo", 1'b1, ls < 8'h20)
    ovf(0, 8'h00, 8'hff, 8'hfc);
    `CHK("m0 hi", 8'h00, hs)
    `CHK("m0 top", 3'b111, ls[7:5])
    ovf(1, 8'h20, 8'hc0, 8'hfe);
    `CHK("m2 hi", 8'hc0, hs)
    `CHK("m2 lo", 1'b1, ls >= 8'hc0)
    ovf(0, 8'h02, 8'hc0, 8'hfe);
    `CHK("m2 t0 hi", 8'hc0, hs)
    `CHK("m2 t0 lo", 1'b1, ls >= 8'hc0)
    fin("modes");
    // Pin counting, then gating by a low interrupt pin in level mode
    wr(ix[2], 8'h00);
    wr(ix[1], 8'h05);
    wr(ix[0], 8'h10);
    pin_u.pulse(0, 5);
    wr(ix[0], 8'h00);
    bus(1'b0, ix[2], 8'h00);
    `CHK("count", 8'h05, rd)
    wr(ix[2], 8'h00);
    wr(ix[1], 8'h0d);
    pin_u.hold(2, 1'b0);
    wr(ix[0], 8'h10);
    pin_u.pulse(0, 3);
    kick(2);
    `CHK("level", 1'b1, flg[2])
    wr(ix[0], 8'h00);
    bus(1'b0, ix[2], 8'h00);
    `CHK("gated", 8'h00, rd)
    pin_u.hold(2, 1'b1);
    repeat (5) @(posedge hclk);
    `CHK("level off", 1'b0, flg[2])
    wr(ix[0], 8'h10);
    pin_u.pulse(0, 3);
    wr(ix[0], 8'h00);
    bus(1'b0, ix[2], 8'h00);
    `CHK("ungated", 8'h03, rd)
    fin("pins");
    // Falling-edge triggering and vector clear
    wr(ix[0], 8'h05);
    pin_u.pulse(3, 1);
    pin_u.pulse(2, 1);
    `CHK("edge", 2'b11, flg[3:2])
    kick(3);
    kick(2);
    `CHK("edge ack", 2'b00, flg[3:2])
    fin("edge");
    // Split mode: timer 0 high byte runs on timer 1 run, timer 1 holds
    wr(ix[3], 8'h10);
    wr(ix[4], 8'hf0);
    wr(ix[2], 8'h00);
    wr(ix[1], 8'h33);
    wr(ix[0], 8'h40);
    while (flg[1] !== 1'b1) @(posedge hclk);
    wr(ix[0], 8'h00);
    bus(1'b0, ix[3], 8'h00);
    `CHK("t1 held", 8'h10, rd)
    bus(1'b0, ix[2], 8'h00);
    `CHK("t0 low", 8'h00, rd)
    bus(1'b0, ix[4], 8'h00);
    `CHK("t0 high", 1'b1, rd < 8'h20)
    fin("split");
    give_verdict();
  end
endmodule
`default_nettype wire
